// >>> rtl/mfp_pkg.sv
package mfp_pkg;

  localparam int          RX_PINS   = 3;
  localparam int          TX_PINS   = 2;
  localparam int          SEL_W     = 4;
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;
  localparam int          SYNC_W    = RX_PINS + TX_PINS + 2;
  localparam int          FRX_BIT   = RX_PINS + TX_PINS;
  localparam int          FTX_BIT   = RX_PINS + TX_PINS + 1;

  localparam logic [7:0]  RX_SEL_OFF = 8'h00;
  localparam logic [7:0]  TX_SEL_OFF = 8'h04;
  localparam logic [7:0]  CTRL_OFF   = 8'h08;
  localparam logic [7:0]  STATUS_OFF = 8'h0C;

  // Every receive pin comes up in the recovered clock function, undriven
  localparam logic [11:0] RX_SEL_RST = 12'hFFF;
  localparam logic [7:0]  TX_SEL_RST = 8'h00;

  localparam logic [3:0]  FN_RX_TERM      = 4'h8;
  localparam logic [3:0]  FN_GPI          = 4'h9;
  localparam logic [3:0]  FN_GENERAL_OUTPUT_HIGH_FN         = 4'hA;
  localparam logic [3:0]  FN_GENERAL_OUTPUT_LOW_FN         = 4'hB;
  localparam logic [3:0]  FN_LOS          = 4'hC;
  localparam logic [3:0]  FN_RX_NEGATIVE_RAIL_OUT         = 4'hE;
  localparam logic [3:0]  FN_RCLK         = 4'hF;
  localparam logic [3:0]  FN_TX_REF_CLK   = 4'h3;
  localparam logic [3:0]  FN_TX_TRISTATE  = 4'h8;
  localparam logic [3:0]  FN_TX_LINE_CLK  = 4'hF;

  typedef struct packed {
    logic       tx_ref_sync_en;
    logic [2:0] rs_ext;
    logic [1:0] rs_legacy;
    logic       frx_dir;
    logic       tx_tristate_bit;
    logic       compat;
    logic       rclk_oe;
    logic       dual_rail;
    logic       term_bit;
    logic       tx_edge;
    logic       rx_edge;
  } ctrl_t;

  localparam int          CTRL_W   = 14;
  localparam logic [13:0] CTRL_RST = 14'h0000;

endpackage

// >>> rtl/line_port_multifunction_pins.sv
// Behaviour
// - Each rx pin and each tx pin has its own 4-bit function selector.
// - After reset every multifunction pin is an input.
// - Output enable follows the selected function; no separate direction.
// - Rx pins sample/launch on framer rx clock edge chosen by rx edge bit.
// - Tx pins sample/launch on framer tx clock edge chosen by tx edge bit.
// - Rx code 1000: input; termination switch is XNOR of pin and bit.
// - Code 1001: input whose level shows in the pin input status.
// - Code 1010 drives the pin constantly high.
// - Code 1011 drives the pin constantly low.
// - Rx code 1100 outputs the current loss-of-signal status.
// - Rx code 1110 outputs negative rail if dual rail, else violation.
// - Rx code 1111, recovered clock output, is the reset default.
// - Recovered clock pin only pulled up until its output enable is set.
// - Clock source select: 2-bit field if compat is 1, else 3-bit.
// - Tx clock input may serve as sync reference of tx oscillator.
// - Tx line clock code drives the transmit line clock out.
// - Tx code 1000: high input tristates line; OR with register bit.
// - Framer rx clock pin is input when its direction bit is 0.
`timescale 1ns/100ps
module line_port_multifunction_pins
(
  input  wire logic                                core_clk_i,
  input  wire logic                                rst_n_i,
  input  wire logic [mfp_pkg::ADDR_W-1:0]          addr_i,
  input  wire logic [mfp_pkg::DATA_W-1:0]          wr_data_i,
  input  wire logic                                wr_en_i,
  input  wire logic                                rd_en_i,
  output logic      [mfp_pkg::DATA_W-1:0]          rd_data_o,
  input  wire logic [mfp_pkg::RX_PINS-1:0]         rx_pin_i,
  output logic      [mfp_pkg::RX_PINS-1:0]         rx_pin_o,
  output logic      [mfp_pkg::RX_PINS-1:0]         rx_pin_oe_o,
  input  wire logic [mfp_pkg::TX_PINS-1:0]         tx_pin_i,
  output logic      [mfp_pkg::TX_PINS-1:0]         tx_pin_o,
  output logic      [mfp_pkg::TX_PINS-1:0]         tx_pin_oe_o,
  input  wire logic                                frx_clk_i,
  output logic                                     frx_clk_o,
  output logic                                     frx_clk_oe_o,
  input  wire logic                                ftx_clk_i,
  input  wire logic                                los_i,
  input  wire logic                                rx_neg_rail_i,
  input  wire logic                                rx_violation_i,
  input  wire logic                                recovered_clk_i,
  input  wire logic                                tx_line_clk_i,
  output logic                                     rx_term_switch_o,
  output logic                                     tx_line_tristate_o,
  output logic                                     tx_ref_clk_o,
  output logic                                     tx_osc_sync_o,
  output logic      [2:0]                          rclk_src_sel_o
);

  localparam int RXN = mfp_pkg::RX_PINS;
  localparam int TXN = mfp_pkg::TX_PINS;

  logic [4*RXN-1:0]             rx_sel_reg;
  logic [4*TXN-1:0]             tx_sel_reg;
  mfp_pkg::ctrl_t               ctrl_reg;
  logic [mfp_pkg::SYNC_W-1:0]   sync1_reg;
  logic [mfp_pkg::SYNC_W-1:0]   sync2_reg;
  logic [mfp_pkg::SYNC_W-1:0]   sync3_reg;
  logic [mfp_pkg::SYNC_W-1:0]   filt_reg;
  logic                         frx_prev_reg;
  logic                         ftx_prev_reg;
  logic                         frx_src;
  logic                         rx_tick;
  logic                         tx_tick;
  logic [RXN-1:0]               rx_cap_reg;
  logic [TXN-1:0]               tx_cap_reg;
  logic [RXN-1:0]               rx_oe_next;
  logic [RXN-1:0]               rx_out_next;
  logic [TXN-1:0]               tx_oe_next;
  logic [TXN-1:0]               tx_out_next;
  logic                         term_pin;
  logic                         tri_pin;
  logic                         ref_found;
  logic                         ref_pin;
  logic [4:0]                   gpi_status;
  logic [7:0]                   status_word;

  // Register writes
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_sel_reg <= mfp_pkg::RX_SEL_RST;
      tx_sel_reg <= mfp_pkg::TX_SEL_RST;
      ctrl_reg   <= mfp_pkg::CTRL_RST;
    end
    else if (wr_en_i)
    begin
      case (addr_i)
        mfp_pkg::RX_SEL_OFF: rx_sel_reg <= wr_data_i[4*RXN-1:0];
        mfp_pkg::TX_SEL_OFF: tx_sel_reg <= wr_data_i[4*TXN-1:0];
        mfp_pkg::CTRL_OFF:   ctrl_reg   <= wr_data_i[mfp_pkg::CTRL_W-1:0];
        default:             ;
      endcase
    end
  end

  assign status_word = {tx_line_tristate_o, rx_term_switch_o, los_i, gpi_status};

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_data_o <= '0;
    else if (rd_en_i)
    begin
      case (addr_i)
        mfp_pkg::RX_SEL_OFF: rd_data_o <= {{(32-4*RXN){1'b0}}, rx_sel_reg};
        mfp_pkg::TX_SEL_OFF: rd_data_o <= {{(32-4*TXN){1'b0}}, tx_sel_reg};
        mfp_pkg::CTRL_OFF:   rd_data_o <= {{(32-mfp_pkg::CTRL_W){1'b0}}, ctrl_reg};
        mfp_pkg::STATUS_OFF: rd_data_o <= {24'h000000, status_word};
        default:             rd_data_o <= '0;
      endcase
    end
    else
      rd_data_o <= '0;
  end

  // Pins and framer clocks come from outside: three stages, accept on agreement
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      filt_reg  <= '1;
    end
    else
    begin
      sync1_reg <= {ftx_clk_i, frx_clk_i, tx_pin_i, rx_pin_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
    end
  end

  // When this end drives the rx framer clock, its own copy paces the pins
  assign frx_src = ctrl_reg.frx_dir ? frx_clk_o : filt_reg[mfp_pkg::FRX_BIT];
  assign rx_tick = ctrl_reg.rx_edge ? (frx_src & ~frx_prev_reg)
                                    : (~frx_src & frx_prev_reg);
  assign tx_tick = ctrl_reg.tx_edge ? (filt_reg[mfp_pkg::FTX_BIT] & ~ftx_prev_reg)
                                    : (~filt_reg[mfp_pkg::FTX_BIT] & ftx_prev_reg);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frx_prev_reg <= 1'b1;
      ftx_prev_reg <= 1'b1;
      frx_clk_o    <= 1'b0;
      frx_clk_oe_o <= 1'b0;
    end
    else
    begin
      frx_prev_reg <= frx_src;
      ftx_prev_reg <= filt_reg[mfp_pkg::FTX_BIT];
      frx_clk_o    <= recovered_clk_i;
      frx_clk_oe_o <= ctrl_reg.frx_dir;
    end
  end

  // Input capture on the selected framer clock edge
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_cap_reg <= '1;
      tx_cap_reg <= '1;
    end
    else
    begin
      if (rx_tick)
        rx_cap_reg <= filt_reg[RXN-1:0];
      if (tx_tick)
        tx_cap_reg <= filt_reg[RXN+TXN-1:RXN];
    end
  end

  // Direction and data per function; output codes drive unless noted
  always_comb
  begin
    for (int i = 0; i < RXN; i++)
    begin
      rx_out_next[i] = rx_pin_o[i];
      rx_oe_next[i]  = 1'b1;
      case (rx_sel_reg[4*i +: 4])
        mfp_pkg::FN_GENERAL_OUTPUT_HIGH_FN:
          if (rx_tick)
            rx_out_next[i] = 1'b1;
        mfp_pkg::FN_GENERAL_OUTPUT_LOW_FN:
          if (rx_tick)
            rx_out_next[i] = 1'b0;
        mfp_pkg::FN_LOS:
          if (rx_tick)
            rx_out_next[i] = los_i;
        mfp_pkg::FN_RX_NEGATIVE_RAIL_OUT:
          if (rx_tick)
            rx_out_next[i] = ctrl_reg.dual_rail ? rx_neg_rail_i : rx_violation_i;
        mfp_pkg::FN_RCLK:
        begin
          // Only the pad pull-up holds the level until software enables it
          rx_oe_next[i]  = ctrl_reg.rclk_oe;
          rx_out_next[i] = recovered_clk_i;
        end
        default: rx_oe_next[i] = 1'b0;
      endcase
    end
    for (int j = 0; j < TXN; j++)
    begin
      tx_out_next[j] = tx_pin_o[j];
      tx_oe_next[j]  = 1'b1;
      case (tx_sel_reg[4*j +: 4])
        mfp_pkg::FN_GENERAL_OUTPUT_HIGH_FN:
          if (tx_tick)
            tx_out_next[j] = 1'b1;
        mfp_pkg::FN_GENERAL_OUTPUT_LOW_FN:
          if (tx_tick)
            tx_out_next[j] = 1'b0;
        mfp_pkg::FN_TX_LINE_CLK: tx_out_next[j] = tx_line_clk_i;
        default: tx_oe_next[j] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_pin_o    <= '1;
      rx_pin_oe_o <= '0;
      tx_pin_o    <= '1;
      tx_pin_oe_o <= '0;
    end
    else
    begin
      rx_pin_o    <= rx_out_next;
      rx_pin_oe_o <= rx_oe_next;
      tx_pin_o    <= tx_out_next;
      tx_pin_oe_o <= tx_oe_next;
    end
  end

  // Input functions; a duplicate selection is a software fault, lowest pin wins
  always_comb
  begin
    term_pin  = 1'b1;
    tri_pin   = 1'b0;
    ref_found = 1'b0;
    ref_pin   = 1'b0;
    for (int i = RXN - 1; i >= 0; i--)
    begin
      if (rx_sel_reg[4*i +: 4] == mfp_pkg::FN_RX_TERM)
        term_pin = rx_cap_reg[i];
      gpi_status[i] = (rx_sel_reg[4*i +: 4] == mfp_pkg::FN_GPI) & rx_cap_reg[i];
    end
    for (int j = TXN - 1; j >= 0; j--)
    begin
      if (tx_sel_reg[4*j +: 4] == mfp_pkg::FN_TX_TRISTATE)
        tri_pin = tx_cap_reg[j];
      if (tx_sel_reg[4*j +: 4] == mfp_pkg::FN_TX_REF_CLK)
      begin
        ref_found = 1'b1;
        ref_pin   = filt_reg[RXN+j];
      end
      gpi_status[RXN+j] = (tx_sel_reg[4*j +: 4] == mfp_pkg::FN_GPI) & tx_cap_reg[j];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_term_switch_o   <= 1'b0;
      tx_line_tristate_o <= 1'b0;
      tx_ref_clk_o       <= 1'b0;
      tx_osc_sync_o      <= 1'b0;
      rclk_src_sel_o     <= 3'h0;
    end
    else
    begin
      rx_term_switch_o   <= ~(term_pin ^ ctrl_reg.term_bit);
      tx_line_tristate_o <= tri_pin | ctrl_reg.tx_tristate_bit;
      tx_ref_clk_o       <= ref_found & ref_pin;
      tx_osc_sync_o      <= ref_found & ref_pin & ctrl_reg.tx_ref_sync_en;
      rclk_src_sel_o     <= ctrl_reg.compat ? {1'b0, ctrl_reg.rs_legacy}
                                            : ctrl_reg.rs_ext;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_reset_all_inputs: assert property ($rose(rst_n_i) |->
    rx_pin_oe_o == '0 && tx_pin_oe_o == '0) else $error("pins driven after reset");
  chk_oe_follows_code: assert property (rx_sel_reg[3:0] == mfp_pkg::FN_LOS |=>
    rx_pin_oe_o[0]) else $error("output enable not set for output function");
  chk_general_output_high_fn_high: assert property (tx_sel_reg[3:0] == mfp_pkg::FN_GENERAL_OUTPUT_HIGH_FN && tx_tick ##1
    tx_sel_reg[3:0] == mfp_pkg::FN_GENERAL_OUTPUT_HIGH_FN |-> tx_pin_o[0] && tx_pin_oe_o[0])
    else $error("high output not driven");
  chk_general_output_low_fn_low: assert property (rx_sel_reg[3:0] == mfp_pkg::FN_GENERAL_OUTPUT_LOW_FN && rx_tick |=>
    !rx_pin_o[0]) else $error("low output not driven");
  chk_los_out: assert property (rx_sel_reg[3:0] == mfp_pkg::FN_LOS && rx_tick |=>
    rx_pin_o[0] == $past(los_i)) else $error("signal absent output mismatch");
  chk_rx_negative_rail_out_select: assert property (rx_sel_reg[11:8] == mfp_pkg::FN_RX_NEGATIVE_RAIL_OUT && rx_tick &&
    !ctrl_reg.dual_rail |=> rx_pin_o[2] == $past(rx_violation_i))
    else $error("violation output mismatch");
  chk_rclk_pull_only: assert property (rx_sel_reg[3:0] == mfp_pkg::FN_RCLK &&
    !ctrl_reg.rclk_oe |=> !rx_pin_oe_o[0]) else $error("clock pin driven before enable");
  chk_rx_edge_capture: assert property (rx_tick |=>
    rx_cap_reg[0] == $past(filt_reg[0])) else $error("rx capture missed edge");
  // Pin a must not also be a termination input, the lowest pin would win
  chk_term_xnor: assert property (rx_sel_reg[7:4] == mfp_pkg::FN_RX_TERM &&
    rx_sel_reg[3:0] != mfp_pkg::FN_RX_TERM |=>
    rx_term_switch_o == ~($past(rx_cap_reg[1]) ^ $past(ctrl_reg.term_bit)))
    else $error("termination switch mismatch");
  chk_tristate_or: assert property (ctrl_reg.tx_tristate_bit |=> tx_line_tristate_o)
    else $error("tristate bit ignored");
  chk_frx_dir: assert property (!ctrl_reg.frx_dir |=> !frx_clk_oe_o)
    else $error("framer rx clock driven as input");
  chk_undefined_idle: assert property (tx_sel_reg[3:0] == 4'h0 |=> !tx_pin_oe_o[0])
    else $error("undefined code drives pin");
  chk_src_sel_compat: assert property (ctrl_reg.compat |=> rclk_src_sel_o[2] == 1'b0)
    else $error("legacy select too wide");

  cov_rx_los: cover property (rx_sel_reg[3:0] == mfp_pkg::FN_LOS && rx_tick);
  cov_rclk_on: cover property (rx_sel_reg[3:0] == mfp_pkg::FN_RCLK && ctrl_reg.rclk_oe ##1
    rx_pin_oe_o[0]);
  cov_tx_tristate: cover property (tx_sel_reg[3:0] == mfp_pkg::FN_TX_TRISTATE ##1
    tx_line_tristate_o);
  cov_ref_sync: cover property (tx_osc_sync_o);

endmodule

// >>> verif/framer_model.sv
`timescale 1ns/100ps
module framer_model
(
  input  wire logic [2:0] dut_rx_i,
  input  wire logic [2:0] dut_rx_oe_i,
  input  wire logic [1:0] dut_tx_i,
  input  wire logic [1:0] dut_tx_oe_i,
  input  wire logic       dut_fclk_i,
  input  wire logic       dut_fclk_oe_i,
  output logic      [2:0] rx_lvl_o,
  output logic      [1:0] tx_lvl_o,
  output logic            frx_clk_o,
  output logic            ftx_clk_o
);
  logic       lclk  = 1'b0;
  logic       run   = 1'b1;
  logic [2:0] rx_en = 3'h0;
  logic [2:0] rx_v  = 3'h0;
  logic [1:0] tx_en = 2'h0;
  logic [1:0] tx_v  = 2'h0;

  // Free running framer clock, frozen only when a test steps it by hand
  always #100 if (run) lclk = ~lclk;

  // Called on a core clock edge, so changes land after that edge
  task hold(input logic v);
    run  <= 1'b0;
    lclk <= v;
  endtask

  task go;
    run <= 1'b1;
  endtask

  // Caller gives each input function except code 1001 to one pin only
  task drive(input logic [2:0] re, input logic [2:0] rv, input logic [1:0] te,
             input logic [1:0] tv);
    rx_en <= re;
    rx_v  <= rv;
    tx_en <= te;
    tx_v  <= tv;
  endtask

  // Pull-ups win where nobody drives; device drive takes the wire
  assign rx_lvl_o  = (dut_rx_oe_i & dut_rx_i) | (~dut_rx_oe_i & ((rx_en & rx_v) | ~rx_en));
  assign tx_lvl_o  = (dut_tx_oe_i & dut_tx_i) | (~dut_tx_oe_i & ((tx_en & tx_v) | ~tx_en));
  assign frx_clk_o = dut_fclk_oe_i ? dut_fclk_i : lclk;
  assign ftx_clk_o = lclk;
endmodule

// >>> verif/line_port_multifunction_pins_test.sv
`timescale 1ns/100ps
module line_port_multifunction_pins_test;
  logic           clk   = 1'b0;
  logic           rst_n = 1'b0;
  logic [7:0]     addr  = 8'h00;
  logic [31:0]    wdata = 32'h0;
  logic           wr_en = 1'b0;
  logic           rd_en = 1'b0;
  logic [31:0]    rd_data;
  logic [31:0]    st;
  logic [2:0]     rx_lvl, rx_o, rx_oe, src_sel;
  logic [1:0]     tx_lvl, tx_o, tx_oe;
  logic           frx_lvl, frx_o, frx_oe, ftx_lvl, term_sw, tristate, ref_clk, osc_sync, e;
  logic           signal_absent_output = 1'b0, neg = 1'b0, viol = 1'b0, rec = 1'b0, txl = 1'b0;
  mfp_pkg::ctrl_t cr;
  int             fails = 0;
  int             comparisons = 0;
  int             cycles = 0;

  line_port_multifunction_pins i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
    .rx_pin_i(rx_lvl), .rx_pin_o(rx_o), .rx_pin_oe_o(rx_oe), .tx_pin_i(tx_lvl),
    .tx_pin_o(tx_o), .tx_pin_oe_o(tx_oe), .frx_clk_i(frx_lvl), .frx_clk_o(frx_o),
    .frx_clk_oe_o(frx_oe), .ftx_clk_i(ftx_lvl), .los_i(signal_absent_output), .rx_neg_rail_i(neg),
    .rx_violation_i(viol), .recovered_clk_i(rec), .tx_line_clk_i(txl),
    .rx_term_switch_o(term_sw), .tx_line_tristate_o(tristate), .tx_ref_clk_o(ref_clk),
    .tx_osc_sync_o(osc_sync), .rclk_src_sel_o(src_sel));

  framer_model i_fr (.dut_rx_i(rx_o), .dut_rx_oe_i(rx_oe), .dut_tx_i(tx_o),
    .dut_tx_oe_i(tx_oe), .dut_fclk_i(frx_o), .dut_fclk_oe_i(frx_oe), .rx_lvl_o(rx_lvl),
    .tx_lvl_o(tx_lvl), .frx_clk_o(frx_lvl), .ftx_clk_o(ftx_lvl));

  always #12.5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      fails++;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 st = rd_data;
  endtask

  task wctrl;
    wr(mfp_pkg::CTRL_OFF, {18'h0, cr});
  endtask

  // Pin launches wait for a framer edge behind the input filter
  task sel(input logic [11:0] r, input logic [7:0] t);
    wr(mfp_pkg::RX_SEL_OFF, {20'h0, r});
    wr(mfp_pkg::TX_SEL_OFF, {24'h0, t});
    cyc(30);
  endtask

  task t_reset;
    chk({rx_oe, tx_oe, frx_oe}, 6'h00);
    rd(mfp_pkg::RX_SEL_OFF);
    chk(st, 32'h00000FFF);
    rd(mfp_pkg::TX_SEL_OFF);
    chk(st, 32'h0);
    rd(8'h10);
    chk(st, 32'h0);
  endtask

  task t_gpo;
    sel(12'hABA, 8'hAB);
    chk({rx_oe, tx_oe}, 5'h1F);
    chk(rx_o, 3'b101);
    chk(tx_o, 2'b10);
  endtask

  task t_gpi;
    logic [4:0] p;
    sel(12'h999, 8'h99);
    for (int k = 0; k < 2; k++)
    begin
      p = k ? 5'h0A : 5'h15;
      i_fr.drive(3'h7, p[2:0], 2'h3, p[4:3]);
      cyc(30);
      rd(mfp_pkg::STATUS_OFF);
      chk(st[4:0], p);
      chk({rx_oe, tx_oe}, 5'h00);
    end
  endtask

  task t_term_tristate;
    cr = '0;
    sel(12'h080, 8'h08);
    for (int t = 0; t < 4; t++)
    begin
      cr.term_bit        = t[0];
      cr.tx_tristate_bit = t[0];
      wctrl;
      i_fr.drive(3'b010, {1'b0, t[1], 1'b0}, 2'b01, {1'b0, t[1]});
      cyc(30);
      e = ~(t[0] ^ t[1]);
      chk(term_sw, e);
      e = t[0] | t[1];
      chk(tristate, e);
      chk({rx_oe, tx_oe}, 5'h00);
    end
    i_fr.drive(3'h0, 3'h0, 2'h0, 2'h0);
  endtask

  task t_los_rx_negative_rail_out;
    sel(12'hEFC, 8'h55);
    for (int t = 0; t < 8; t++)
    begin
      cr.dual_rail = t[2];
      wctrl;
      signal_absent_output  <= t[0];
      neg  <= t[1];
      viol <= t[0];
      cyc(30);
      chk(rx_o[0], t[0]);
      e = t[2] ? t[1] : t[0];
      chk(rx_o[2], e);
      rd(mfp_pkg::STATUS_OFF);
      chk(st[5], t[0]);
      chk({rx_oe, tx_oe}, 5'b10100);
    end
  endtask

  task t_clocks;
    cr = '0;
    cr.rclk_oe        = 1'b1;
    cr.compat         = 1'b1;
    cr.rs_legacy      = 2'h2;
    cr.rs_ext         = 3'h5;
    cr.frx_dir        = 1'b1;
    cr.tx_ref_sync_en = 1'b1;
    wctrl;
    sel(12'hFFF, 8'h3F);
    chk(rx_oe, 3'h7);
    chk(tx_oe, 2'b01);
    chk(frx_oe, 1'b1);
    chk(src_sel, 3'h2);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      rec <= k[0];
      txl <= k[0];
      @(posedge clk);
      #1 chk(rx_o, {3{k[0]}});
      chk(tx_o[0], k[0]);
      chk(frx_o, k[0]);
    end
    for (int v = 0; v < 2; v++)
    begin
      i_fr.drive(3'h0, 3'h0, 2'b10, {v[0], 1'b0});
      cyc(30);
      chk(ref_clk, v[0]);
      chk(osc_sync, v[0]);
    end
    cr = '0;
    cr.rs_ext = 3'h5;
    wctrl;
    cyc(3);
    chk(src_sel, 3'h5);
    chk(osc_sync, 1'b0);
    chk({frx_oe, rx_oe}, 4'h0);
  endtask

  // Framer clock parked so the unselected edge comes first
  task t_edge(input logic sel_e);
    cr = '0;
    cr.rx_edge = sel_e;
    cr.tx_edge = sel_e;
    wctrl;
    i_fr.go;
    sel(12'hAAA, 8'hAA);
    i_fr.hold(sel_e);
    cyc(20);
    sel(12'hBBB, 8'hBB);
    chk({rx_o, tx_o}, 5'h1F);
    i_fr.hold(~sel_e);
    cyc(20);
    chk({rx_o, tx_o}, 5'h1F);
    i_fr.hold(sel_e);
    cyc(20);
    chk({rx_o, tx_o}, 5'h00);
    i_fr.go;
  endtask

  initial
  begin
    cr = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    t_reset;
    t_gpo;
    t_gpi;
    t_term_tristate;
    t_los_rx_negative_rail_out;
    t_clocks;
    t_edge(1'b1);
    t_edge(1'b0);
    tally_and_finish;
  end
endmodule
